// ===== lnb_ctrl_bank.sv
// Write-only control register bank for a dual channel supply regulator.
`timescale 1ns/10ps
`default_nettype none
`include "lnb_ctrl_defines.svh"
module lnb_ctrl_bank #(
  parameter int unsigned OC_DETECT_CYCLES = `OC_DETECT_US * `CLK_MHZ
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Serial engine byte interface
  input wire logic rx_frame_start,
  input wire logic rx_data_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_ack_done,
  // Analogue and pin inputs, one bit per channel
  input wire logic [1:0] overcurrent_det,
  input wire logic [1:0] out_above_set,
  input wire logic [1:0] out_below_clear,
  input wire logic [1:0] ext_tone_in,
  input wire logic [1:0] internal_osc_in,
  input wire logic [1:0] ext_mod_gating_sel,
  input wire logic [1:0] external_modulation_pin,
  // Control settings, one bit per channel
  output logic [1:0] level_step_bit0,
  output logic [1:0] level_step_bit1,
  output logic [1:0] level_step_bit2,
  output logic [1:0] range_high_select,
  output logic [1:0] overcurrent_shutoff_timer_en,
  output logic [1:0] output_on,
  output logic [1:0] tone_source_internal,
  output logic [1:0] tone_gate_on,
  output logic [1:0] cable_test_on,
  // Derived drives and status, one bit per channel
  output logic [1:0] linear_reg_on,
  output logic [1:0] current_limit_on,
  output logic [1:0] test_current_on,
  output logic [1:0] boost_raise_on,
  output logic [1:0] tone_drive,
  output logic [1:0] channel_tripped,
  output logic [1:0] cable_missing_flag
);
  lnb_ctrl_pkg::wr_state_t state_q;
  logic [7:0] hold_q;
  logic commit;
  logic [1:0] sel;
  logic first_q;
  lnb_ctrl_pkg::volt_reg_t [1:0] vreg_q;
  lnb_ctrl_pkg::tone_reg_t [1:0] treg_q;
  logic [1:0] vwr;
  logic [1:0] twr;
  logic [1:0] trip;

  //------------------------------------------------------------------
  // Write sequencing
  //------------------------------------------------------------------
  // One data byte is accepted per transfer; it is held until its
  // acknowledge clock completes, and later bytes are ignored.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      state_q <= lnb_ctrl_pkg::WR_IDLE;
    else if (rx_frame_start)
      state_q <= lnb_ctrl_pkg::WR_IDLE;
    else
    begin
      unique case (state_q)
        lnb_ctrl_pkg::WR_IDLE:
          if (rx_data_valid)
            state_q <= lnb_ctrl_pkg::WR_HELD;
        lnb_ctrl_pkg::WR_HELD:
          if (rx_ack_done)
            state_q <= lnb_ctrl_pkg::WR_DONE; // [R18]
        lnb_ctrl_pkg::WR_DONE:
          state_q <= lnb_ctrl_pkg::WR_DONE;
        // The unused fourth code falls back to idle.
        default:
          state_q <= lnb_ctrl_pkg::WR_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      hold_q <= 8'h00;
    else if (state_q == lnb_ctrl_pkg::WR_IDLE && rx_data_valid && !rx_frame_start)
      hold_q <= rx_data;
  end

  assign commit = state_q == lnb_ctrl_pkg::WR_HELD && rx_ack_done && !rx_frame_start; // [R18]
  assign sel = hold_q[`SEL_HI:`SEL_LO];

  //------------------------------------------------------------------
  // Register select decode
  //------------------------------------------------------------------
  assign vwr[0] = commit && sel == `SEL_CH1_VOLT; // [R02]
  assign vwr[1] = commit && sel == `SEL_CH2_VOLT; // [R02]
  assign twr[0] = commit && sel == `SEL_CH1_TONE; // [R01]
  assign twr[1] = commit && sel == `SEL_CH2_TONE; // [R01]

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      first_q <= 1'b1;
    else
      first_q <= 1'b0;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  AST_ONE_BYTE_PER_XFER: assert property ( // [R18]
    state_q == lnb_ctrl_pkg::WR_DONE && !rx_frame_start |=> !commit)
    else $error("second byte committed in one transfer");
  AST_WAIT_FOR_ACK: assert property ( // [R18]
    !commit |=> $stable(vreg_q) && $stable(treg_q))
    else $error("register changed without acknowledged byte");
  AST_RESET_ZERO: assert property ( // [R16]
    first_q |-> vreg_q == '0 && treg_q == '0 && output_on == 2'b00)
    else $error("control settings not zero after reset");

  //------------------------------------------------------------------
  // Per-channel registers and drives
  //------------------------------------------------------------------
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_ch
    oc_link_if lnk ();
    logic lvl0_q, lvl1_q, lvl2_q, rng_q, tmr_q, on_q;
    logic tsrc_q, tgate_q, ctest_q;
    logic lin_q, lim_q, isrc_q, boost_q, tone_q, trip_q, miss_q;
    logic tone_sel;
    logic gate;

    oc_shutoff_timer #(
      .OC_DETECT_CYCLES(OC_DETECT_CYCLES)
    ) u_timer (
      .core_clk(core_clk),
      .nrst(nrst),
      .lnk(lnk.timer)
    );

    assign lnk.oc_det = overcurrent_det[ch];
    assign lnk.timer_en = vreg_q[ch].overcurrent_shutoff_timer_en;
    assign lnk.rearm = vwr[ch];
    assign trip[ch] = lnk.trip;

    // Voltage, timer and enable register.
    always_ff @(posedge core_clk or negedge nrst)
    begin
      if (!nrst)
        vreg_q[ch] <= `VOLT_RESET; // [R16]
      else if (vwr[ch])
        vreg_q[ch] <= hold_q[`VOLT_W-1:0]; // [R02]
    end

    // Tone and cable test register; bits 5:3 of the byte are dropped.
    always_ff @(posedge core_clk or negedge nrst)
    begin
      if (!nrst)
        treg_q[ch] <= `TONE_RESET; // [R16]
      else if (twr[ch])
        treg_q[ch] <= hold_q[`TONE_W-1:0]; // [R01] [R15]
    end

    // Setting outputs mirror the registers.
    always_ff @(posedge core_clk or negedge nrst)
    begin
      if (!nrst)
      begin
        lvl0_q <= 1'b0;
        lvl1_q <= 1'b0;
        lvl2_q <= 1'b0;
        rng_q <= 1'b0;
        tmr_q <= 1'b0;
        on_q <= 1'b0;
        tsrc_q <= 1'b0;
        tgate_q <= 1'b0;
        ctest_q <= 1'b0;
      end
      else
      begin
        lvl0_q <= vreg_q[ch].level_step[0]; // [R04]
        lvl1_q <= vreg_q[ch].level_step[1]; // [R04]
        lvl2_q <= vreg_q[ch].level_step[2]; // [R04]
        rng_q <= vreg_q[ch].range_high_select; // [R03]
        tmr_q <= vreg_q[ch].overcurrent_shutoff_timer_en;
        on_q <= vreg_q[ch].output_on; // [R08]
        tsrc_q <= treg_q[ch].tone_source_internal;
        tgate_q <= treg_q[ch].tone_gate_on;
        ctest_q <= treg_q[ch].cable_test_on;
      end
    end

    // Regulator, test source and boost drives.
    always_ff @(posedge core_clk or negedge nrst)
    begin
      if (!nrst)
      begin
        lin_q <= 1'b0;
        lim_q <= 1'b0;
        isrc_q <= 1'b0;
        boost_q <= 1'b0;
        trip_q <= 1'b0;
      end
      else
      begin
        lin_q <= vreg_q[ch].output_on && !trip[ch] && !treg_q[ch].cable_test_on; // [R05] [R08] [R12]
        lim_q <= overcurrent_det[ch] && !vreg_q[ch].overcurrent_shutoff_timer_en; // [R06]
        isrc_q <= treg_q[ch].cable_test_on; // [R12]
        boost_q <= treg_q[ch].cable_test_on; // [R12]
        trip_q <= trip[ch];
      end
    end

    // Tone source and gating.
    assign tone_sel = treg_q[ch].tone_source_internal ? internal_osc_in[ch]
                                                      : ext_tone_in[ch]; // [R09]
    assign gate = ext_mod_gating_sel[ch] ? external_modulation_pin[ch]
                                         : treg_q[ch].tone_gate_on; // [R10]

    always_ff @(posedge core_clk or negedge nrst)
    begin
      if (!nrst)
        tone_q <= 1'b0;
      else
        tone_q <= tone_sel && gate; // [R09] [R10]
    end

    // Cable missing flag with set and clear thresholds.
    // Setting wins when both comparators report in the same cycle.
    always_ff @(posedge core_clk or negedge nrst)
    begin
      if (!nrst)
        miss_q <= 1'b0;
      else if (!treg_q[ch].cable_test_on)
        miss_q <= 1'b0; // [R19]
      else if (out_above_set[ch])
        miss_q <= 1'b1; // [R13]
      else if (out_below_clear[ch])
        miss_q <= 1'b0; // [R14]
    end

    assign level_step_bit0[ch] = lvl0_q;
    assign level_step_bit1[ch] = lvl1_q;
    assign level_step_bit2[ch] = lvl2_q;
    assign range_high_select[ch] = rng_q;
    assign overcurrent_shutoff_timer_en[ch] = tmr_q;
    assign output_on[ch] = on_q;
    assign tone_source_internal[ch] = tsrc_q;
    assign tone_gate_on[ch] = tgate_q;
    assign cable_test_on[ch] = ctest_q;
    assign linear_reg_on[ch] = lin_q;
    assign current_limit_on[ch] = lim_q;
    assign test_current_on[ch] = isrc_q;
    assign boost_raise_on[ch] = boost_q;
    assign tone_drive[ch] = tone_q;
    assign channel_tripped[ch] = trip_q;
    assign cable_missing_flag[ch] = miss_q;

    AST_TONE_REG_LOAD: assert property ( // [R01]
      twr[ch] |=> treg_q[ch] == $past(hold_q[2:0]) && $stable(vreg_q))
      else $error("tone register not loaded from selected byte");
    AST_VOLT_REG_LOAD: assert property ( // [R02]
      vwr[ch] |=> vreg_q[ch] == $past(hold_q[5:0]) && $stable(treg_q))
      else $error("voltage register not loaded from selected byte");
    AST_RANGE_OUT: assert property ( // [R03]
      vwr[ch] ##1 !vwr[ch] |=> rng_q == hold_q[3])
      else $error("range output does not follow bit 3");
    AST_LEVEL_OUT: assert property ( // [R04]
      vwr[ch] ##1 !vwr[ch] |=> {lvl2_q, lvl1_q, lvl0_q} == $past(vreg_q[ch].level_step))
      else $error("level step outputs do not follow bits 2:0");
    AST_TRIP_OFF: assert property ( // [R05]
      trip[ch] |=> !lin_q)
      else $error("regulator on while channel tripped");
    AST_LIMIT_HOLD: assert property ( // [R06]
      overcurrent_det[ch] && !vreg_q[ch].overcurrent_shutoff_timer_en |=> lim_q)
      else $error("current limit not held with timer off");
    AST_ENABLE_OFF: assert property ( // [R08]
      !vreg_q[ch].output_on |=> !lin_q && !on_q)
      else $error("output on while enable bit clear");
    AST_TONE_SRC: assert property ( // [R09]
      treg_q[ch].tone_source_internal && gate |=> tone_q == $past(internal_osc_in[ch]))
      else $error("internal tone not routed");
    AST_TONE_GATE: assert property ( // [R10]
      !ext_mod_gating_sel[ch] && !treg_q[ch].tone_gate_on |=> !tone_q)
      else $error("tone present while gated off");
    AST_CABLE_TEST_DRIVES: assert property ( // [R12]
      treg_q[ch].cable_test_on |=> isrc_q && boost_q && !lin_q)
      else $error("cable test drives wrong");
    AST_MISS_SET: assert property ( // [R13]
      treg_q[ch].cable_test_on && out_above_set[ch] |=> miss_q)
      else $error("cable missing flag not set");
    AST_MISS_CLEAR: assert property ( // [R14]
      treg_q[ch].cable_test_on && !out_above_set[ch] && out_below_clear[ch] |=> !miss_q)
      else $error("cable missing flag not cleared");
    AST_MISS_IDLE: assert property ( // [R19]
      !treg_q[ch].cable_test_on |=> !miss_q)
      else $error("cable missing flag set outside test");
  end
endmodule
`default_nettype wire

// ===== lnb_ctrl_defines.svh
// Constants for the dual channel supply control register bank.
//------------------------------------------------------------------
// Functional notes
// R01: Byte bits 7:6 select register; 10 and 11 are channel 1/2 tone-test registers.
// R02: Select 00 and 01 are channel 1/2 voltage, timer and enable registers.
// R03: Voltage bit 3 picks low range 12.709 V or high range 18.042 V.
// R04: Voltage bits 2:0 raise the level in 333 mV steps, eight codes.
// R05: Timer bit 4 set: persistent overcurrent switches the channel output off.
// R06: Timer bit clear: no switch-off, channel stays in current limit.
// R07: Master should keep the overcurrent timer bit set on both channels.
// R08: Voltage bit 5 switches the channel output on, clear disables it.
// R09: Tone bit 0 picks external tone input or internal oscillator.
// R10: Tone bit 1 gates the tone unless the modulation pin does gating.
// R11: Master sets test, enable and all voltage select bits for cable test.
// R12: Cable test bit 2 stops regulator, enables 1 mA source, raises boost.
// R13: During test, output above 21 V sets the cable missing flag.
// R14: During test, output below 19.95 V clears the flag (hysteresis).
// R15: Tone register bits 3 to 5 have no function.
// R16: All control settings come up zero at power-up.
// R17: Master sends one control byte per write transfer, after the address.
// R18: Load only after full byte acknowledged; other registers stay unchanged.
// R19: With cable test off the cable missing flag stays zero.
//------------------------------------------------------------------
`ifndef LNB_CTRL_DEFINES_SVH
`define LNB_CTRL_DEFINES_SVH
`define SEL_CH1_VOLT 2'h0
`define SEL_CH2_VOLT 2'h1
`define SEL_CH1_TONE 2'h2
`define SEL_CH2_TONE 2'h3
`define SEL_HI 7
`define SEL_LO 6
`define VOLT_W 6
`define TONE_W 3
`define VOLT_RESET 6'h00
`define TONE_RESET 3'h0
`define CLK_MHZ 125
`define OC_DETECT_US 100
`endif

// ===== lnb_ctrl_pkg.sv
// Types shared by the control register bank modules.
`default_nettype none
package lnb_ctrl_pkg;
  typedef struct packed {
    logic output_on;
    logic overcurrent_shutoff_timer_en;
    logic range_high_select;
    logic [2:0] level_step;
  } volt_reg_t;
  typedef struct packed {
    logic cable_test_on;
    logic tone_gate_on;
    logic tone_source_internal;
  } tone_reg_t;
  typedef enum logic [1:0] {WR_IDLE, WR_HELD, WR_DONE} wr_state_t;
endpackage
`default_nettype wire

// ===== oc_link_if.sv
// Carrier between the bank and one overcurrent shut-off timer.
`timescale 1ns/10ps
`default_nettype none
interface oc_link_if;
  logic oc_det;
  logic timer_en;
  logic rearm;
  logic trip;
  modport bank (output oc_det, output timer_en, output rearm, input trip);
  modport timer (input oc_det, input timer_en, input rearm, output trip);
endinterface
`default_nettype wire

// ===== oc_shutoff_timer.sv
// Overcurrent detection timer for one supply channel.
`timescale 1ns/10ps
`default_nettype none
`include "lnb_ctrl_defines.svh"
module oc_shutoff_timer #(
  parameter int unsigned OC_DETECT_CYCLES = `OC_DETECT_US * `CLK_MHZ
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Link to the bank
  oc_link_if.timer lnk
);
  localparam int CW = $clog2(OC_DETECT_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(OC_DETECT_CYCLES - 1);

  logic [CW-1:0] cnt_q;
  logic trip_q;

  //------------------------------------------------------------------
  // Persistence counter
  //------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      cnt_q <= '0;
    else if (!lnk.oc_det || !lnk.timer_en)
      cnt_q <= '0;
    else if (cnt_q != LAST)
      cnt_q <= cnt_q + CW'(1);
  end

  //------------------------------------------------------------------
  // Trip latch; a new trip wins over a rearm in the same cycle.
  //------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      trip_q <= 1'b0;
    else if (lnk.oc_det && lnk.timer_en && cnt_q == LAST)
      trip_q <= 1'b1; // [R05]
    else if (lnk.rearm)
      trip_q <= 1'b0;
  end

  assign lnk.trip = trip_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  AST_TRIP_NEEDS_TIME: assert property ( // [R05]
    $rose(trip_q) |-> $past(cnt_q) == LAST && $past(lnk.oc_det))
    else $error("trip without full detection time");
  AST_NO_TRIP_TIMER_OFF: assert property ( // [R06]
    !lnk.timer_en |=> !$rose(trip_q))
    else $error("trip while timer disabled");
endmodule
`default_nettype wire

// ===== serial_master_model.sv
// Byte-level model of the two-wire master that writes the control bank.
`timescale 1ns/10ps
`default_nettype none
module serial_master_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Byte strobes to the bank
  output logic rx_frame_start,
  output logic rx_data_valid,
  output logic [7:0] rx_data,
  output logic rx_ack_done
);
  initial
  begin
    rx_frame_start = 1'b0;
    rx_data_valid = 1'b0;
    rx_data = 8'h00;
    rx_ack_done = 1'b0;
  end

  // One data byte, gap idle cycles before its acknowledge.
  task automatic put_byte(input logic [7:0] b, input int gap);
    @(posedge core_clk);
    rx_frame_start <= 1'b0;
    rx_data_valid <= 1'b1;
    rx_data <= b;
    @(posedge core_clk);
    rx_data_valid <= 1'b0;
    // A released data bus must not keep showing the byte.
    rx_data <= ~b;
    repeat (gap) @(posedge core_clk);
    rx_ack_done <= 1'b1;
    @(posedge core_clk);
    rx_ack_done <= 1'b0;
  endtask

  // A write transfer; extra adds a forbidden second byte that the bank must drop.
  task automatic xfer(input logic [7:0] b, input logic [7:0] b2, input logic extra,
                      input int gap);
    @(posedge core_clk);
    rx_frame_start <= 1'b1;
    put_byte(b, gap);
    if (extra)
      put_byte(b2, 0);
  endtask
endmodule
`default_nettype wire

// ===== dual_lnb_control_register_bank_bench.sv
// Self-checking testbench of the dual channel supply control register bank.
`timescale 1ns/10ps
`default_nettype none
module dual_lnb_control_register_bank_bench;
  logic core_clk;
  logic nrst;
  logic rx_frame_start, rx_data_valid, rx_ack_done;
  logic [7:0] rx_data;
  logic [1:0] overcurrent_det, out_above_set, out_below_clear, ext_tone_in;
  logic [1:0] internal_osc_in, ext_mod_gating_sel, external_modulation_pin;
  logic [1:0] level_step_bit0, level_step_bit1, level_step_bit2, range_high_select;
  logic [1:0] overcurrent_shutoff_timer_en, output_on, tone_source_internal;
  logic [1:0] tone_gate_on, cable_test_on, linear_reg_on, current_limit_on;
  logic [1:0] test_current_on, boost_raise_on, tone_drive, channel_tripped;
  logic [1:0] cable_missing_flag;
  int err_count = 0;
  int samples_checked = 0;

  serial_master_model u_master (.core_clk, .nrst, .rx_frame_start, .rx_data_valid,
    .rx_data, .rx_ack_done);

  lnb_ctrl_bank #(.OC_DETECT_CYCLES(8)) u_dut (.core_clk, .nrst, .rx_frame_start,
    .rx_data_valid, .rx_data, .rx_ack_done, .overcurrent_det, .out_above_set,
    .out_below_clear, .ext_tone_in, .internal_osc_in, .ext_mod_gating_sel,
    .external_modulation_pin, .level_step_bit0, .level_step_bit1, .level_step_bit2,
    .range_high_select, .overcurrent_shutoff_timer_en, .output_on, .tone_source_internal,
    .tone_gate_on, .cable_test_on, .linear_reg_on, .current_limit_on, .test_current_on,
    .boost_raise_on, .tone_drive, .channel_tripped, .cable_missing_flag);

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  //----------------------------------------------------------------
  // Helpers
  //----------------------------------------------------------------
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Waits n edges and lets the last edge settle.
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // One committed write; settings show two edges after the commit.
  task automatic wr(input logic [7:0] b, input int gap);
    u_master.xfer(b, 8'h00, 1'b0, gap);
    step(2);
  endtask

  initial
  begin
    step(20000);
    err_count++;
    report_and_stop;
  end

  //----------------------------------------------------------------
  // Tests
  //----------------------------------------------------------------
  initial
  begin
    nrst = 1'b0;
    overcurrent_det = 2'b00;
    out_above_set = 2'b00;
    out_below_clear = 2'b00;
    ext_tone_in = 2'b00;
    internal_osc_in = 2'b10;
    ext_mod_gating_sel = 2'b00;
    external_modulation_pin = 2'b00;
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    step(1);
    chk("volt after reset", {level_step_bit0, level_step_bit1, level_step_bit2,
      range_high_select}, 8'h00);
    chk("ctrl after reset", {overcurrent_shutoff_timer_en, output_on, tone_source_internal,
      tone_gate_on}, 8'h00);
    chk("drive after reset", {cable_test_on, linear_reg_on, test_current_on,
      boost_raise_on}, 8'h00);
    chk("status after reset", {tone_drive, channel_tripped, cable_missing_flag,
      current_limit_on}, 8'h00);
    for (int c = 0; c < 16; c++)
    begin
      wr({4'h6, c[3:0]}, c % 3);
      chk("ch2 level code", {4'h0, range_high_select[1], level_step_bit2[1],
        level_step_bit1[1], level_step_bit0[1]}, {4'h0, c[3:0]});
      chk("enable timer linear", {2'h0, output_on, overcurrent_shutoff_timer_en,
        linear_reg_on}, 8'h22);
    end
    wr(8'h38, 0);
    chk("ch1 write", {2'h0, output_on, overcurrent_shutoff_timer_en, range_high_select},
      8'h37);
    u_master.xfer(8'h40, 8'h00, 1'b1, 1);
    step(2);
    chk("second byte dropped", {6'h0, output_on}, 8'h01);
    wr(8'hb8, 0);
    chk("tone unused bits", {5'h0, tone_source_internal[0], tone_gate_on[0],
      cable_test_on[0]}, 8'h00);
    for (int t = 0; t < 4; t++)
    begin
      wr({6'h30, t[1:0]}, 0);
      chk("ch2 tone", {5'h0, tone_source_internal[1], tone_gate_on[1], tone_drive[1]},
        {5'h0, t[0], t[1], t[0] & t[1]});
    end
    @(posedge core_clk);
    internal_osc_in <= 2'b00;
    step(2);
    chk("internal tone follows", {6'h0, tone_drive}, 8'h00);
    @(posedge core_clk);
    ext_tone_in <= 2'b10;
    wr(8'hc2, 0);
    chk("external tone", {6'h0, tone_drive}, 8'h02);
    @(posedge core_clk);
    ext_mod_gating_sel <= 2'b10;
    step(2);
    chk("pin gates low", {6'h0, tone_drive}, 8'h00);
    @(posedge core_clk);
    external_modulation_pin <= 2'b10;
    wr(8'hc0, 0);
    chk("pin gates high", {6'h0, tone_drive}, 8'h02);
    @(posedge core_clk);
    overcurrent_det <= 2'b01;
    step(5);
    chk("no early trip", {6'h0, channel_tripped}, 8'h00);
    step(10);
    chk("trip", {4'h0, channel_tripped, linear_reg_on}, 8'h04);
    @(posedge core_clk);
    overcurrent_det <= 2'b00;
    wr(8'h38, 0);
    chk("trip cleared", {4'h0, channel_tripped, linear_reg_on}, 8'h01);
    wr(8'h20, 0);
    @(posedge core_clk);
    overcurrent_det <= 2'b01;
    step(20);
    chk("current limit", {2'h0, channel_tripped, current_limit_on, linear_reg_on},
      8'h05);
    @(posedge core_clk);
    overcurrent_det <= 2'b00;
    wr(8'h3f, 0);
    wr(8'h84, 0);
    chk("cable test drives", {5'h0, test_current_on[0], boost_raise_on[0],
      linear_reg_on[0]}, 8'h06);
    chk("cable test bit", {6'h0, cable_test_on}, 8'h01);
    @(posedge core_clk);
    out_above_set <= 2'b01;
    step(2);
    chk("flag set", {6'h0, cable_missing_flag}, 8'h01);
    @(posedge core_clk);
    out_above_set <= 2'b00;
    step(2);
    chk("flag held", {6'h0, cable_missing_flag}, 8'h01);
    @(posedge core_clk);
    out_below_clear <= 2'b01;
    step(2);
    chk("flag cleared", {6'h0, cable_missing_flag}, 8'h00);
    @(posedge core_clk);
    out_below_clear <= 2'b00;
    out_above_set <= 2'b01;
    step(2);
    chk("flag set again", {6'h0, cable_missing_flag}, 8'h01);
    wr(8'h80, 0);
    chk("flag off test", {4'h0, cable_missing_flag, test_current_on}, 8'h00);
    report_and_stop;
  end
endmodule
`default_nettype wire
